//--- logic/reset_source_cfg.svh
// Constants for the reset source controller
`ifndef RESET_SOURCE_CFG_SVH
`define RESET_SOURCE_CFG_SVH

// Register offsets (byte addresses, chosen locally)
`define REG_GUARD_CODE      8'h00
`define REG_SOURCE_FLAGS    8'h04
`define REG_THRESHOLD_SEL   8'h08
`define REG_WDT_CODE        8'h0c
`define REG_MODE_STATUS     8'h10
`define REG_IRQ_STATUS      8'h14
`define REG_IRQ_ENABLE      8'h18
`define REG_IRQ_CLEAR       8'h1c

// Guard code values
`define GUARD_RESET_VALUE   8'h55
`define GUARD_ALT_VALUE     8'haa

// Threshold select codes
`define THR_SEL_A           8'h66
`define THR_SEL_B           8'h55
`define THR_SEL_C           8'h33
`define THR_SEL_D           8'h99
`define THR_SEL_E           8'haa
`define THR_DISABLE         8'hf0
`define THR_RESET_VALUE     8'h66

// Watchdog enable code (5 bits) values and reset value
`define WDT_CODE_A          5'h0a
`define WDT_CODE_B          5'h15
`define WDT_CODE_RESET      5'h0a

// Flag bit positions in the source flag register
`define FLAG_WDT_REG        0
`define FLAG_THR_REG        1
`define FLAG_LOW_VOLT       2
`define FLAG_GUARD          3

// Interrupt status bits
`define IRQ_GUARD           0
`define IRQ_THR_REG         1
`define IRQ_LOW_VOLT        2
`define IRQ_WDT_REG         3
`define IRQ_TIMEOUT         4
`define IRQ_WIDTH           5

// Timing: soft reset delay and low voltage qualify time
`define SOFT_RESET_DELAY_NS 1000
`define LV_QUALIFY_NS       120000
`define CLOCK_PERIOD_NS     25
`define SOFT_RESET_CYCLES   ((`SOFT_RESET_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define LV_QUALIFY_CYCLES   (`LV_QUALIFY_NS / `CLOCK_PERIOD_NS)

// Length of the full reset pulse issued on system_reset.full; the warm pulse is one cycle
`define RESET_PULSE_CYCLES  4

`endif

//--- logic/reset_source_pkg.sv
// Types for the reset source controller
package reset_source_pkg;

	// Power modes reported by the core
	typedef enum logic [1:0] {
		mode_fast  = 2'h0,
		mode_slow  = 2'h1,
		mode_idle  = 2'h2,
		mode_sleep = 2'h3
	} power_mode_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} reg_req_t;

	// Reset kinds issued to the core
	typedef struct packed {
		logic full;   // Full system reset
		logic warm;   // Clear program counter and stack pointer only
	} reset_out_t;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		st_run   = 3'b001,
		st_delay = 3'b010,
		st_pulse = 3'b100
	} seq_state_t;

	// Cause latched for a pending reset
	typedef struct packed {
		logic guard;
		logic thr;
		logic wdt;
		logic low_volt;
	} cause_t;

endpackage

//--- logic/reset_source_control.sv
// Reset source controller: guard codes, low voltage qualification, watchdog reset handling
// Notes on behaviour
// RULE_01: Guard codes 55/aa idle, others reset later
// RULE_02: Invalid guard code sets guard flag
// RULE_03: Guard register reloads except watchdog warm reset
// RULE_04: Flag register bits 7..4 read zero
// RULE_05: Guard flag hardware set, software clear only
// RULE_06: Low supply must outlast qualify time
// RULE_07: Six defined threshold codes, f0 disables
// RULE_08: Undefined threshold code resets, reloads 66
// RULE_09: Undefined threshold code sets its flag
// RULE_10: Real low voltage reset keeps threshold
// RULE_11: Low voltage reset off in idle/sleep
// RULE_12: Qualified low voltage sets sticky flag
// RULE_13: Run mode timeout: full reset, timeout flag
// RULE_14: Low-power timeout: warm reset, timeout flag
// RULE_15: Invalid watchdog code sets its flag
// RULE_16: Low-power timeout also sets powerdown flag
// RULE_17: Soft reset delay is parameterised count
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_cfg.svh"

module reset_source_control #(
	parameter int SOFT_DELAY_CYCLES = `SOFT_RESET_CYCLES,
	parameter int LV_QUALIFY_CYCLES = `LV_QUALIFY_CYCLES
) (
	// Clock and master reset
	input  wire logic                        clock,
	input  wire logic                        reset,
	// Register port
	input  wire reset_source_pkg::reg_req_t  reg_req,
	output var  logic [7:0]                  reg_rdata,
	// Supply and core status
	input  wire logic                        low_supply,
	input  wire reset_source_pkg::power_mode_t power_mode,
	input  wire logic                        watchdog_expired,
	input  wire logic                        powerdown_entered,
	// Reset outputs
	output var  reset_source_pkg::reset_out_t system_reset,
	output var  logic                        watchdog_timeout_flag,
	output var  logic                        powerdown_flag,
	output var  logic                        irq
);
	import reset_source_pkg::*;

	localparam int DCW = $clog2(SOFT_DELAY_CYCLES + 1);
	localparam int QCW = $clog2(LV_QUALIFY_CYCLES + 2);
	localparam int PCW = 3;

	// Input synchronisers for the analog low supply level
	logic                 supply_meta;      // First stage, read only by second
	logic                 supply_sync;      // Safe low supply level

	// Software visible registers
	logic [7:0]           reset_guard_bits;        // Guard code register
	logic [7:0]           threshold_select_bits;   // Threshold select register
	logic [4:0]           watchdog_enable_code;    // Watchdog enable code
	logic                 guard_reset_flag;
	logic                 low_voltage_reset_flag;
	logic                 threshold_register_reset_flag;
	logic                 watchdog_register_reset_flag;
	logic [`IRQ_WIDTH-1:0] irq_status;
	logic [`IRQ_WIDTH-1:0] irq_enable;

	// Sequencer state
	seq_state_t           state;
	cause_t               cause;
	logic [DCW-1:0]       delay_count;
	logic [PCW-1:0]       pulse_count;
	logic [QCW-1:0]       qual_count;

	// Next values
	logic [7:0]           next_guard;
	logic [7:0]           next_threshold;
	logic [4:0]           next_wdt_code;
	logic                 next_guard_flag;
	logic                 next_lv_flag;
	logic                 next_thr_flag;
	logic                 next_wdt_flag;
	logic [`IRQ_WIDTH-1:0] next_irq_status;
	logic [`IRQ_WIDTH-1:0] next_irq_enable;
	seq_state_t           next_state;
	cause_t               next_cause;
	logic [DCW-1:0]       next_delay_count;
	logic [PCW-1:0]       next_pulse_count;
	logic [QCW-1:0]       next_qual_count;
	reset_out_t           next_system_reset;
	logic                 next_timeout_flag;
	logic                 next_powerdown_flag;
	logic [7:0]           next_rdata;

	// Decoded conditions
	logic                 guard_bad;
	logic                 thr_bad;
	logic                 wdt_bad;
	logic                 low_power;
	logic                 lv_enabled;
	logic                 lv_qualified;
	logic                 wdt_full;
	logic                 wdt_warm;
	logic                 wr_hit;

	// Guard code check, used by the guard decode only
	function automatic logic guard_ok(input logic [7:0] v);
		return (v == `GUARD_RESET_VALUE) || (v == `GUARD_ALT_VALUE);
	endfunction

	// Threshold code check, disable code counted as defined
	function automatic logic threshold_ok(input logic [7:0] v);
		return (v == `THR_SEL_A) || (v == `THR_SEL_B) || (v == `THR_SEL_C) ||
			(v == `THR_SEL_D) || (v == `THR_SEL_E) || (v == `THR_DISABLE);
	endfunction

	// Two flop synchroniser for low supply
	always_ff @(posedge clock) begin
		if (reset) begin
			supply_meta <= 1'b0;
			supply_sync <= 1'b0;
		end else begin
			supply_meta <= low_supply;
			supply_sync <= supply_meta;
		end
	end

	// Condition decode
	always_comb begin
		// RULE_01: guard code check
		guard_bad  = !guard_ok(reset_guard_bits);
		// RULE_07: threshold code decode
		thr_bad    = !threshold_ok(threshold_select_bits);
		wdt_bad    = (watchdog_enable_code != `WDT_CODE_A) && (watchdog_enable_code != `WDT_CODE_B);
		// RULE_11: off in low power
		low_power  = (power_mode == mode_idle) || (power_mode == mode_sleep);
		lv_enabled = !low_power && (threshold_select_bits != `THR_DISABLE) && !thr_bad;
		// RULE_06: qualified only past count
		lv_qualified = (qual_count > QCW'(LV_QUALIFY_CYCLES));
		// RULE_13: run mode timeout is full
		wdt_full   = watchdog_expired && !low_power;
		// RULE_14: low power timeout is warm
		wdt_warm   = watchdog_expired && low_power;
		wr_hit     = reg_req.write;
	end

	// Low supply duration counter; any gap restarts qualification
	always_comb begin
		next_qual_count = qual_count;
		if (!supply_sync || !lv_enabled || state != st_run)
			next_qual_count = '0;
		else if (!lv_qualified)
			next_qual_count = qual_count + QCW'(1);
	end

	always_ff @(posedge clock) begin
		if (reset)
			qual_count <= '0;
		else
			qual_count <= next_qual_count;
	end

	// Sequencer: delay for register faults, then a reset pulse
	always_comb begin
		next_state        = state;
		next_cause        = cause;
		next_delay_count  = delay_count;
		next_pulse_count  = pulse_count;
		next_system_reset = '0;
		case (state)
			st_run: begin
				if (lv_qualified) begin
					// Immediate reset, supply already qualified
					next_cause       = '{guard: 1'b0, thr: 1'b0, wdt: 1'b0, low_volt: 1'b1};
					next_state       = st_pulse;
					next_pulse_count = '0;
				end else if (wdt_full) begin
					next_cause       = '0;
					next_state       = st_pulse;
					next_pulse_count = '0;
				end else if (guard_bad || thr_bad || wdt_bad) begin
					next_cause       = '{guard: guard_bad, thr: thr_bad, wdt: wdt_bad,
						low_volt: 1'b0};
					next_state       = st_delay;
					next_delay_count = '0;
				end
			end
			st_delay: begin
				// RULE_17: same delay for every register fault source
				if (delay_count >= DCW'(SOFT_DELAY_CYCLES - 1)) begin
					next_state       = st_pulse;
					next_pulse_count = '0;
				end else begin
					next_delay_count = delay_count + DCW'(1);
				end
			end
			st_pulse: begin
				next_system_reset.full = 1'b1;
				if (pulse_count >= PCW'(`RESET_PULSE_CYCLES - 1)) begin
					next_state = st_run;
					next_cause = '0;
				end else begin
					next_pulse_count = pulse_count + PCW'(1);
				end
			end
			default: begin
				next_state = st_run;
				next_cause = '0;
			end
		endcase
		// Warm reset is a single pulse beside any sequence
		next_system_reset.warm = wdt_warm;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state         <= st_run;
			cause         <= '0;
			delay_count   <= '0;
			pulse_count   <= '0;
			system_reset  <= '0;
		end else begin
			state         <= next_state;
			cause         <= next_cause;
			delay_count   <= next_delay_count;
			pulse_count   <= next_pulse_count;
			system_reset  <= next_system_reset;
		end
	end

	// Register file and flags
	always_comb begin
		logic pulse_end;
		pulse_end       = (state == st_pulse) && (pulse_count >= PCW'(`RESET_PULSE_CYCLES - 1));
		next_guard      = reset_guard_bits;
		next_threshold  = threshold_select_bits;
		next_wdt_code   = watchdog_enable_code;
		next_guard_flag = guard_reset_flag;
		next_lv_flag    = low_voltage_reset_flag;
		next_thr_flag   = threshold_register_reset_flag;
		next_wdt_flag   = watchdog_register_reset_flag;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		next_timeout_flag   = watchdog_timeout_flag;
		next_powerdown_flag = powerdown_flag;
		// Software writes first, hardware sets afterwards win
		if (wr_hit) begin
			case (reg_req.addr)
				`REG_GUARD_CODE:    next_guard     = reg_req.wdata;
				`REG_THRESHOLD_SEL: next_threshold = reg_req.wdata;
				`REG_WDT_CODE:      next_wdt_code  = reg_req.wdata[4:0];
				`REG_SOURCE_FLAGS: begin
					// RULE_05: software clears only
					next_guard_flag = guard_reset_flag & reg_req.wdata[`FLAG_GUARD];
					next_lv_flag    = low_voltage_reset_flag & reg_req.wdata[`FLAG_LOW_VOLT];
					next_thr_flag   = threshold_register_reset_flag & reg_req.wdata[`FLAG_THR_REG];
					next_wdt_flag   = watchdog_register_reset_flag & reg_req.wdata[`FLAG_WDT_REG];
				end
				`REG_MODE_STATUS: begin
					// Software may clear the status copies
					next_timeout_flag   = watchdog_timeout_flag & reg_req.wdata[0];
					next_powerdown_flag = powerdown_flag & reg_req.wdata[1];
				end
				`REG_IRQ_ENABLE:    next_irq_enable = reg_req.wdata[`IRQ_WIDTH-1:0];
				`REG_IRQ_CLEAR:     next_irq_status = irq_status & ~reg_req.wdata[`IRQ_WIDTH-1:0];
				default: begin
					// Unmapped or read-only: ignored
				end
			endcase
		end
		if (powerdown_entered)
			next_powerdown_flag = 1'b1;
		// RULE_02: guard flag set on fault
		if (state == st_delay && cause.guard) begin
			next_guard_flag = 1'b1;
			next_irq_status[`IRQ_GUARD] = 1'b1;
		end
		// RULE_09: threshold fault flag
		if (state == st_delay && cause.thr) begin
			next_thr_flag = 1'b1;
			next_irq_status[`IRQ_THR_REG] = 1'b1;
		end
		// RULE_15: watchdog code fault flag
		if (state == st_delay && cause.wdt) begin
			next_wdt_flag = 1'b1;
			next_irq_status[`IRQ_WDT_REG] = 1'b1;
		end
		// RULE_12: qualified low voltage flag
		if (state == st_run && lv_qualified) begin
			next_lv_flag = 1'b1;
			next_irq_status[`IRQ_LOW_VOLT] = 1'b1;
		end
		// RULE_13: timeout flag on full timeout
		if (wdt_full && state == st_run && !lv_qualified) begin
			next_timeout_flag = 1'b1;
			next_irq_status[`IRQ_TIMEOUT] = 1'b1;
		end
		// RULE_16: low power sets both flags
		if (wdt_warm) begin
			next_timeout_flag   = 1'b1;
			next_powerdown_flag = 1'b1;
			next_irq_status[`IRQ_TIMEOUT] = 1'b1;
		end
		// Full reset reload at end of pulse; warm reset never reloads
		if (pulse_end) begin
			// RULE_03: guard reloads on full reset
			next_guard    = `GUARD_RESET_VALUE;
			next_wdt_code = `WDT_CODE_RESET;
			// RULE_10: keep threshold on low voltage
			// RULE_08: reload after threshold fault
			if (!cause.low_volt)
				next_threshold = `THR_RESET_VALUE;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			reset_guard_bits              <= `GUARD_RESET_VALUE;
			threshold_select_bits         <= `THR_RESET_VALUE;
			watchdog_enable_code          <= `WDT_CODE_RESET;
			guard_reset_flag              <= 1'b0;
			low_voltage_reset_flag        <= 1'b0;
			threshold_register_reset_flag <= 1'b0;
			watchdog_register_reset_flag  <= 1'b0;
			irq_status                    <= '0;
			irq_enable                    <= '0;
			watchdog_timeout_flag         <= 1'b0;
			powerdown_flag                <= 1'b0;
		end else begin
			reset_guard_bits              <= next_guard;
			threshold_select_bits         <= next_threshold;
			watchdog_enable_code          <= next_wdt_code;
			guard_reset_flag              <= next_guard_flag;
			low_voltage_reset_flag        <= next_lv_flag;
			threshold_register_reset_flag <= next_thr_flag;
			watchdog_register_reset_flag  <= next_wdt_flag;
			irq_status                    <= next_irq_status;
			irq_enable                    <= next_irq_enable;
			watchdog_timeout_flag         <= next_timeout_flag;
			powerdown_flag                <= next_powerdown_flag;
		end
	end

	// Read data, one cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = 8'h00;
		if (reg_req.read) begin
			case (reg_req.addr)
				`REG_GUARD_CODE:    next_rdata = reset_guard_bits;
				// RULE_04: upper nibble reads zero
				`REG_SOURCE_FLAGS:  next_rdata = {4'h0, guard_reset_flag, low_voltage_reset_flag,
					threshold_register_reset_flag, watchdog_register_reset_flag};
				`REG_THRESHOLD_SEL: next_rdata = threshold_select_bits;
				`REG_WDT_CODE:      next_rdata = {3'h0, watchdog_enable_code};
				`REG_MODE_STATUS:   next_rdata = {6'h00, powerdown_flag, watchdog_timeout_flag};
				`REG_IRQ_STATUS:    next_rdata = {3'h0, irq_status};
				`REG_IRQ_ENABLE:    next_rdata = {3'h0, irq_enable};
				default:            next_rdata = 8'h00;
			endcase
		end
	end

	// Registered read data and interrupt line
	always_ff @(posedge clock) begin
		if (reset) begin
			reg_rdata <= 8'h00;
			irq       <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			irq       <= |(next_irq_status & next_irq_enable);
		end
	end

endmodule
`default_nettype wire

//--- sim/reset_source_control_sva.sv
// Port checker for the reset source controller
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_cfg.svh"

module reset_source_control_sva #(
	parameter int SOFT_DELAY_CYCLES = 3,
	parameter int LV_QUALIFY_CYCLES = 5
) (
	// Clock and reset
	input wire logic                          clock,
	input wire logic                          reset,
	// Register port
	input wire reset_source_pkg::reg_req_t    reg_req,
	input wire logic [7:0]                    reg_rdata,
	// Supply and core status
	input wire logic                          low_supply,
	input wire reset_source_pkg::power_mode_t power_mode,
	input wire logic                          watchdog_expired,
	input wire logic                          powerdown_entered,
	// Reset outputs
	input wire reset_source_pkg::reset_out_t  system_reset,
	input wire logic                          watchdog_timeout_flag,
	input wire logic                          powerdown_flag,
	input wire logic                          irq
);
	import reset_source_pkg::*;
	// Window for the delayed reset; slack covers the decode cycle
	localparam int SD_LO = SOFT_DELAY_CYCLES;
	localparam int SD_HI = SOFT_DELAY_CYCLES + 4;
	wire logic guard_wr = reg_req.write && reg_req.addr == `REG_GUARD_CODE;
	wire logic guard_ok = reg_req.wdata == 8'h55 || reg_req.wdata == 8'haa;
	wire logic low_pwr  = power_mode == mode_idle || power_mode == mode_sleep;
	wire logic st_wr    = reg_req.write && reg_req.addr == `REG_MODE_STATUS;
	wire logic clr_to   = st_wr && !reg_req.wdata[0];  // Timeout flag clear
	wire logic clr_pd   = st_wr && !reg_req.wdata[1];  // Powerdown flag clear

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	chk_bad_guard_reset: assert property (guard_wr && !guard_ok && !system_reset.full
		|-> ##[SD_LO:SD_HI] system_reset.full) else $error("no delayed reset after bad guard");
	chk_good_guard_quiet: assert property (guard_wr && guard_ok && !system_reset.full
		|=> !system_reset.full [*3]) else $error("reset after valid guard code");
	chk_flags_top_zero: assert property (reg_req.read && reg_req.addr == `REG_SOURCE_FLAGS
		|=> reg_rdata[7:4] == 4'h0) else $error("flag bits 7..4 not zero");
	chk_run_timeout_full: assert property (watchdog_expired && !low_pwr
		|-> ##[1:4] (system_reset.full && watchdog_timeout_flag)) else $error("run timeout");
	chk_idle_timeout_warm: assert property (watchdog_expired && low_pwr
		|=> (system_reset.warm && !system_reset.full) ##1 !system_reset.warm)
		else $error("low power timeout pulse wrong");
	chk_idle_pd_set: assert property (watchdog_expired && low_pwr
		|-> ##[1:2] (powerdown_flag && watchdog_timeout_flag)) else $error("flags not set");
	chk_run_pd_kept: assert property (watchdog_expired && !low_pwr && !powerdown_entered
		&& !reg_req.write |=> $stable(powerdown_flag)) else $error("powerdown flag moved");
	chk_pulse_four: assert property ($rose(system_reset.full)
		|-> system_reset.full [*4] ##1 !system_reset.full) else $error("full pulse length");
	chk_to_sticky: assert property ($fell(watchdog_timeout_flag) |-> $past(clr_to))
		else $error("timeout flag fell without clear");
	chk_pd_sticky: assert property ($fell(powerdown_flag) |-> $past(clr_pd))
		else $error("powerdown flag fell without clear");

	// Main scenarios reached
	cover property (system_reset.warm);
	cover property ($rose(system_reset.full) && low_supply);
	cover property (irq);
endmodule

bind reset_source_control reset_source_control_sva #(
	.SOFT_DELAY_CYCLES(SOFT_DELAY_CYCLES),
	.LV_QUALIFY_CYCLES(LV_QUALIFY_CYCLES)
) i_reset_source_control_sva (
	.clock(clock), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.low_supply(low_supply), .power_mode(power_mode), .watchdog_expired(watchdog_expired),
	.powerdown_entered(powerdown_entered), .system_reset(system_reset),
	.watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq)
);
`default_nettype wire

//--- sim/reset_source_control_tb.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
`include "reset_source_cfg.svh"

module reset_source_control_tb;
	import reset_source_pkg::*;
	localparam int SD = 3;  // Short soft delay keeps the run brief
	localparam int LQ = 5;  // Short qualify count
	// Design stimulus and observation
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	reg_req_t    reg_req = '0;
	logic [7:0]  reg_rdata;
	logic        low_supply = 1'b0;
	power_mode_t power_mode = mode_fast;
	logic        watchdog_expired = 1'b0;
	logic        powerdown_entered = 1'b0;
	reset_out_t  system_reset;
	logic        watchdog_timeout_flag;
	logic        powerdown_flag;
	logic        irq;
	// Bookkeeping
	int          n_errors = 0;
	int          samples_checked = 0;
	int          n_full = 0;  // Full reset pulses seen
	int          n_warm = 0;  // Warm reset pulses seen
	int          base;
	int          bw;
	logic        full_q = 1'b0;
	logic [7:0]  thr [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};

	// Clock
	always #12.5 clock = ~clock;

	reset_source_control #(.SOFT_DELAY_CYCLES(SD), .LV_QUALIFY_CYCLES(LQ)) i_reset_source_control (
		.clock(clock), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.low_supply(low_supply), .power_mode(power_mode), .watchdog_expired(watchdog_expired),
		.powerdown_entered(powerdown_entered), .system_reset(system_reset),
		.watchdog_timeout_flag(watchdog_timeout_flag), .powerdown_flag(powerdown_flag), .irq(irq)
	);

	// Count reset pulses; edge detect on full so a long pulse counts once
	always @(posedge clock) begin
		full_q <= system_reset.full;
		if (system_reset.full === 1'b1 && full_q !== 1'b1)
			n_full++;
		if (system_reset.warm === 1'b1)
			n_warm++;
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		reg_req <= '0;
	endtask

	// Read strobe, data taken in the following cycle only
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		reg_req <= '0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Bounded wait for a new full reset, then let the pulse end
	task wait_rise;
		for (int i = 0; i < 60 && n_full == base; i++)
			@(posedge clock);
		repeat (8) @(posedge clock);
	endtask

	// Supply low for n cycles
	task low_for(input int n);
		@(posedge clock);
		low_supply <= 1'b1;
		repeat (n) @(posedge clock);
		low_supply <= 1'b0;
		repeat (20) @(posedge clock);
	endtask

	// Watchdog overflow in a given mode
	task timeout_in(input power_mode_t m);
		repeat (4) @(posedge clock);
		power_mode <= m;
		watchdog_expired <= 1'b1;
		@(posedge clock);
		watchdog_expired <= 1'b0;
		repeat (12) @(posedge clock);
		power_mode <= mode_fast;
	endtask

	task give_verdict;
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rd(`REG_GUARD_CODE, 8'h55);
		rd(`REG_SOURCE_FLAGS, 8'h00);
		rd(`REG_THRESHOLD_SEL, 8'h66);
		rd(8'h20, 8'h00);
		// Both idle guard codes, then a bad one with irq masked
		base = n_full;
		wr(`REG_GUARD_CODE, 8'haa);
		wr(`REG_GUARD_CODE, 8'h55);
		repeat (30) @(posedge clock);
		check(8'(n_full - base), 8'h00);
		wr(`REG_GUARD_CODE, 8'h12);
		wait_rise();
		check(8'(n_full - base), 8'h01);
		rd(`REG_GUARD_CODE, 8'h55);
		rd(`REG_SOURCE_FLAGS, 8'h08);
		check({7'h0, irq}, 8'h00);
		rd(`REG_IRQ_STATUS, 8'h01);
		wr(`REG_IRQ_ENABLE, 8'h1f);
		@(posedge clock);
		#1 check({7'h0, irq}, 8'h01);
		wr(`REG_IRQ_CLEAR, 8'h1f);
		wr(`REG_IRQ_ENABLE, 8'h00);
		#1 check({7'h0, irq}, 8'h00);
		wr(`REG_SOURCE_FLAGS, 8'hff);
		rd(`REG_SOURCE_FLAGS, 8'h08);
		wr(`REG_SOURCE_FLAGS, 8'h00);
		rd(`REG_SOURCE_FLAGS, 8'h00);
		// Every defined threshold code is kept
		base = n_full;
		foreach (thr[i]) begin
			wr(`REG_THRESHOLD_SEL, thr[i]);
			rd(`REG_THRESHOLD_SEL, thr[i]);
		end
		low_for(LQ + 6);
		check(8'(n_full - base), 8'h00);
		wr(`REG_THRESHOLD_SEL, 8'h3c);
		wait_rise();
		check(8'(n_full - base), 8'h01);
		rd(`REG_THRESHOLD_SEL, 8'h66);
		rd(`REG_SOURCE_FLAGS, 8'h02);
		wr(`REG_SOURCE_FLAGS, 8'h00);
		// Supply dips: short, in sleep, then qualified
		wr(`REG_THRESHOLD_SEL, 8'h33);
		base = n_full;
		low_for(LQ);
		check(8'(n_full - base), 8'h00);
		power_mode <= mode_sleep;
		low_for(LQ + 6);
		check(8'(n_full - base), 8'h00);
		power_mode <= mode_fast;
		low_for(LQ + 6);
		check(8'(n_full - base), 8'h01);
		rd(`REG_THRESHOLD_SEL, 8'h33);
		rd(`REG_SOURCE_FLAGS, 8'h04);
		wr(`REG_SOURCE_FLAGS, 8'h00);
		// Watchdog enable code
		base = n_full;
		wr(`REG_WDT_CODE, 8'h15);
		repeat (30) @(posedge clock);
		check(8'(n_full - base), 8'h00);
		wr(`REG_WDT_CODE, 8'h1f);
		wait_rise();
		check(8'(n_full - base), 8'h01);
		rd(`REG_SOURCE_FLAGS, 8'h01);
		wr(`REG_SOURCE_FLAGS, 8'h00);
		// Timeouts in run and low-power modes
		wr(`REG_GUARD_CODE, 8'haa);
		// Powerdown flag set first so a run timeout must leave it alone
		powerdown_entered <= 1'b1;
		@(posedge clock);
		powerdown_entered <= 1'b0;
		base = n_full;
		timeout_in(mode_slow);
		check(8'(n_full - base), 8'h01);
		rd(`REG_MODE_STATUS, 8'h03);
		rd(`REG_GUARD_CODE, 8'h55);
		wr(`REG_MODE_STATUS, 8'h00);
		wr(`REG_GUARD_CODE, 8'haa);
		base = n_full;
		bw = n_warm;
		timeout_in(mode_idle);
		check(8'(n_warm - bw), 8'h01);
		check(8'(n_full - base), 8'h00);
		#1 check({6'h0, powerdown_flag, watchdog_timeout_flag}, 8'h03);
		rd(`REG_GUARD_CODE, 8'haa);
		wr(`REG_MODE_STATUS, 8'h00);
		rd(`REG_MODE_STATUS, 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire
